/* pixel_clock_video_ctrl.sv */
// command registers, load and programmable clock dividers, blank deskew,
// digital video level steering and phase sync pulse
// assumes host strobes and pixel inputs are synchronous to the pixel clock
`timescale 1ns/1ps
module pixel_clock_video_ctrl
  import vdac_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        host_addr_sel,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [9:0]  host_wdata,
  output logic      [9:0]  host_rdata_r,
  input  wire pixel_word_t pix_in,
  input  wire logic        pix_valid,
  output logic             pix_ready_r,
  input  wire logic        video_run,
  output chan_out_t        red_current_out_r,
  output chan_out_t        green_current_out_r,
  output chan_out_t        blue_current_out_r,
  output logic      [2:0]  pedestal_on_r,
  output logic             green_sync_on_r,
  output logic             phase_sync_output_r,
  output logic             word_load_clock_out_r,
  output logic             programmable_clock_out_r
);

  logic [7:0]  addr_r, addr_nxt, cr2_r, cr2_nxt, cmd3_r, cmd3_nxt;
  logic [9:0]  rdata_nxt;
  logic [1:0]  mux_sel, pck_sel;
  logic [3:0]  dly_sel;
  logic [5:0]  tap;
  logic [2:0]  mux_factor;

  // mux factor, used by both the load clock and the blank tap
  function automatic logic [2:0] factor_of(input logic [1:0] code);
    case (code)
      MUX_2TO1: factor_of = 3'h2;
      MUX_4TO1: factor_of = 3'h4;
      default:  factor_of = 3'h1;
    endcase
  endfunction : factor_of

  always_comb begin
    mux_sel    = cmd3_r[CMD3_MUX_LSB +: 2];
    dly_sel    = cmd3_r[CMD3_DLY_LSB +: 4];
    pck_sel    = cmd3_r[CMD3_PCK_LSB +: 2];
    mux_factor = factor_of(mux_sel);
    tap        = 6'(dly_sel * mux_factor);
  end

  // host port: address write, then data access to the selected register
  always_comb begin
    addr_nxt  = addr_r;
    cr2_nxt   = cr2_r;
    cmd3_nxt  = cmd3_r;
    rdata_nxt = host_rdata_r;
    if (host_wr && host_addr_sel) begin
      addr_nxt = host_wdata[7:0];
    end else if (host_wr) begin
      case (addr_r)
        ADDR_CR2: cr2_nxt = host_wdata[7:0];
        ADDR_CMD3: begin
          cmd3_nxt = host_wdata[7:0];
          // reserved mux code is refused, the old ratio stays
          if (host_wdata[CMD3_MUX_LSB +: 2] == MUX_RSVD) begin
            cmd3_nxt[CMD3_MUX_LSB +: 2] = cmd3_r[CMD3_MUX_LSB +: 2];
          end
        end
        default: cr2_nxt = cr2_r; // revision and unknown: no effect
      endcase
    end
    if (host_rd) begin
      case ({host_addr_sel, addr_r})
        {1'b0, ADDR_CR2}: rdata_nxt = {2'h0, cr2_r};
        {1'b0, ADDR_CMD3}: rdata_nxt = {2'h0, cmd3_r};
        {1'b0, ADDR_REV}: rdata_nxt = {2'h0, REVISION_CODE};
        default:          rdata_nxt = host_addr_sel ? {2'h0, addr_r} : 10'h000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_r       <= ADDR_RESET;
      cr2_r        <= CR2_RESET;
      cmd3_r       <= CMD3_RESET;
      host_rdata_r <= 10'h000;
    end else begin
      addr_r       <= addr_nxt;
      cr2_r        <= cr2_nxt;
      cmd3_r       <= cmd3_nxt;
      host_rdata_r <= rdata_nxt;
    end
  end

  // load clock: one-cycle strobe per load period, steady high at 1:1
  logic [1:0] ld_cnt_r, ld_cnt_nxt;
  logic       ld_nxt;
  always_comb begin
    ld_cnt_nxt = (ld_cnt_r >= 2'(mux_factor - 3'h1)) ? 2'h0 : ld_cnt_r + 2'h1;
    ld_nxt     = ld_cnt_nxt == 2'h0;
  end

  // programmable clock: toggle every 2, 4, 8 or 16 cycles
  logic [3:0] pc_cnt_r, pc_cnt_nxt, pc_half;
  logic       pc_nxt;
  always_comb begin
    // shift amount kept three bits wide so code 11 reaches a half period of 16
    pc_half    = 4'((5'h1 << (3'(pck_sel) + 3'h1)) - 5'h1);
    pc_cnt_nxt = (pc_cnt_r >= pc_half) ? 4'h0 : pc_cnt_r + 4'h1;
    pc_nxt     = (pc_cnt_r >= pc_half) ? !programmable_clock_out_r : programmable_clock_out_r;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ld_cnt_r                 <= 2'h0;
      word_load_clock_out_r    <= 1'b0;
      pc_cnt_r                 <= 4'h0;
      programmable_clock_out_r <= 1'b0;
    end else begin
      ld_cnt_r                 <= ld_cnt_nxt;
      word_load_clock_out_r    <= ld_nxt;
      pc_cnt_r                 <= pc_cnt_nxt;
      programmable_clock_out_r <= pc_nxt;
    end
  end

  // pixel buffer; video_run low stalls the drain so the buffer fills
  pixel_word_t fifo_word;
  logic        fifo_valid;
  pixel_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock      (clock),
    .reset_n    (reset_n),
    .in_data    (pix_in),
    .in_valid   (pix_valid),
    .in_ready_r (pix_ready_r),
    .out_data_r (fifo_word),
    .out_valid_r(fifo_valid),
    .out_ready  (video_run)
  );

  // input stage: an idle word shows blank level while starved
  pixel_word_t pix_r, pix_nxt;
  logic [BLANK_TAPS-1:0] blank_pipe_r, blank_pipe_nxt;
  logic        blank_eff, trig_src, src_prev_r, src_prev_nxt;
  always_comb begin
    pix_nxt        = (fifo_valid && video_run) ? fifo_word : pixel_word_t'{sync_n: 1'b1, blank_n: 1'b0, default: '0};
    blank_pipe_nxt = {blank_pipe_r[BLANK_TAPS-2:0], pix_r.blank_n};
    // blank arrives earlier than data; the tap deskews it
    blank_eff      = (tap == 6'h0) ? pix_r.blank_n : blank_pipe_r[tap - 6'h1];
    trig_src       = cr2_r[CR2_TRIG_BIT] ? blank_eff : pix_r.sync_n;
    src_prev_nxt   = trig_src;
  end

  // output stage: current steering per channel
  chan_out_t red_nxt, green_nxt, blue_nxt;
  logic [2:0] ped_nxt;
  logic       gsync_nxt, phase_nxt;
  always_comb begin
    red_nxt.bits   = blank_eff ? pix_r.red   : 10'h000;
    green_nxt.bits = blank_eff ? pix_r.green : 10'h000;
    blue_nxt.bits  = blank_eff ? pix_r.blue  : 10'h000;
    red_nxt.bits_n   = ~red_nxt.bits;
    green_nxt.bits_n = ~green_nxt.bits;
    blue_nxt.bits_n  = ~blue_nxt.bits;
    // pedestal only with blank inactive; sync current only on green
    ped_nxt   = {3{blank_eff && cr2_r[CR2_PED_BIT]}};
    gsync_nxt = cr2_r[CR2_SYNC_BIT] && pix_r.sync_n;
    phase_nxt = src_prev_r && !trig_src; // registered beside colours
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pix_r               <= '{sync_n: 1'b1, blank_n: 1'b0, default: '0};
      blank_pipe_r        <= '0;
      src_prev_r          <= 1'b0;
      red_current_out_r   <= '{bits: 10'h000, bits_n: 10'h3ff};
      green_current_out_r <= '{bits: 10'h000, bits_n: 10'h3ff};
      blue_current_out_r  <= '{bits: 10'h000, bits_n: 10'h3ff};
      pedestal_on_r       <= 3'h0;
      green_sync_on_r     <= 1'b0;
      phase_sync_output_r <= 1'b0;
    end else begin
      pix_r               <= pix_nxt;
      blank_pipe_r        <= blank_pipe_nxt;
      src_prev_r          <= src_prev_nxt;
      red_current_out_r   <= red_nxt;
      green_current_out_r <= green_nxt;
      blue_current_out_r  <= blue_nxt;
      pedestal_on_r       <= ped_nxt;
      green_sync_on_r     <= gsync_nxt;
      phase_sync_output_r <= phase_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  mux_reserved_a: assert property (mux_sel != MUX_RSVD)
    else $error("reserved mux code stored");
  // only judged while the ratio stays at 4:1 for the whole load period
  load_quarter_a: assert property ((word_load_clock_out_r && mux_sel == MUX_4TO1)
    ##1 (mux_sel == MUX_4TO1) [*3]
    |=> word_load_clock_out_r && !$past(word_load_clock_out_r) && !$past(word_load_clock_out_r, 2)
    && !$past(word_load_clock_out_r, 3))
    else $error("load clock not pixel clock over four");
  prog_clock_a: assert property ($rose(programmable_clock_out_r) && pck_sel == 2'h0 && pc_cnt_r == 4'h0
    |-> ##1 programmable_clock_out_r ##1 (!programmable_clock_out_r || pck_sel != 2'h0))
    else $error("programmable clock half period wrong");
  rev_read_a: assert property (host_rd && !host_addr_sel && addr_r == ADDR_REV
    |=> host_rdata_r == {2'h0, REVISION_CODE})
    else $error("revision read wrong");
  complement_out_a: assert property (red_current_out_r.bits_n == ~red_current_out_r.bits)
    else $error("complement output mismatch");
  blank_level_a: assert property (!blank_eff |=> red_current_out_r.bits == 10'h000
    && pedestal_on_r == 3'h0)
    else $error("blank does not force blank level");
  sync_green_a: assert property (!pix_r.sync_n |=> !green_sync_on_r)
    else $error("sync level not reached on green");
  blank_tap_a: assert property (tap == 6'h1 |-> blank_eff == $past(pix_r.blank_n))
    else $error("blank delay tap wrong");
  phase_trigger_a: assert property (src_prev_r && !trig_src |=> phase_sync_output_r)
    else $error("phase pulse missing on falling edge");
  phase_in_step_a: assert property (phase_sync_output_r && $past(cr2_r[CR2_TRIG_BIT])
    |-> red_current_out_r.bits == 10'h000)
    else $error("phase pulse out of step with colour");

  fifo_full_c:   cover property (!pix_ready_r);
  mux4_c:        cover property (mux_sel == MUX_4TO1 && word_load_clock_out_r);
  phase_pulse_c: cover property (phase_sync_output_r && green_sync_on_r == 1'b0);

endmodule : pixel_clock_video_ctrl

/* vdac_pkg.sv */
// constants, field layouts and carriers for the pixel clock and video level block
// assumes one pixel clock domain and an indirect host register port
// What this block does
// - two-bit code picks 1:1, 2:1, 4:1 muxing
// - load clock strobes once per mux factor pixel clocks, steady high at 1:1
// - blank delayed 0..15 extra load clock periods
// - programmable clock is pixel clock over 4..32
// - revision register read only, returns revision value
// - one bits to true output, zeros to complement
// - blank forces blank or sync level, ignores data
// - sync only on green; pedestal selects black offset
// - phase pulse on falling sync or blank, selectable
// - phase pulse shares colour output pipeline
package vdac_pkg;

  // indirect register addresses
  localparam logic [7:0] ADDR_CR2      = 8'h06;
  localparam logic [7:0] ADDR_CMD3     = 8'h07;
  localparam logic [7:0] ADDR_REV      = 8'h0b;
  localparam logic [7:0] REVISION_CODE = 8'h01; // arbitrary value

  // reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] CR2_RESET  = 8'h00;
  localparam logic [7:0] CMD3_RESET = 8'h00;

  // second command register fields
  localparam int CR2_TRIG_BIT  = 1;   // 1: blank triggers, 0: sync triggers
  localparam int CR2_SYNC_BIT  = 2;   // sync encoded onto green
  localparam int CR2_PED_BIT   = 3;   // black pedestal current on

  // third command register fields
  localparam int CMD3_PCK_LSB  = 0;
  localparam int CMD3_DLY_LSB  = 2;
  localparam int CMD3_MUX_LSB  = 6;

  // multiplex codes
  localparam logic [1:0] MUX_1TO1 = 2'h0;
  localparam logic [1:0] MUX_2TO1 = 2'h1;
  localparam logic [1:0] MUX_RSVD = 2'h2;
  localparam logic [1:0] MUX_4TO1 = 2'h3;

  // pipeline and buffer sizes
  localparam int BLANK_TAPS = 60;     // 15 periods at 4:1
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 32;

  typedef struct packed {
    logic       sync_n;
    logic       blank_n;
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } pixel_word_t;

  typedef struct packed {
    logic [9:0] bits;   // true-output bit currents
    logic [9:0] bits_n; // complement-output bit currents
  } chan_out_t;

endpackage : vdac_pkg

/* pixel_fifo.sv */
// first-in first-out buffer for pixel words, registered read data
// assumes a single clock and that the drain side may stall freely
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready_r,
  output logic      [WIDTH-1:0] out_data_r,
  output logic                  out_valid_r,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop, ovalid_nxt, iready_nxt;

  // pointer and count bookkeeping; read word leaves through a register
  always_comb begin
    push       = in_valid && in_ready_r;
    pop        = (cnt_r != '0) && (!out_valid_r || out_ready);
    wp_nxt     = push ? wp_r + 1'b1 : wp_r;
    rp_nxt     = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt    = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ovalid_nxt = pop || (out_valid_r && !out_ready);
    iready_nxt = cnt_nxt != DEPTH[AW:0];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_r        <= '0;
      rp_r        <= '0;
      cnt_r       <= '0;
      out_valid_r <= 1'b0;
      in_ready_r  <= 1'b0;
    end else begin
      wp_r        <= wp_nxt;
      rp_r        <= rp_nxt;
      cnt_r       <= cnt_nxt;
      out_valid_r <= ovalid_nxt;
      in_ready_r  <= iready_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) mem[wp_r] <= in_data;
    if (pop) out_data_r <= mem[rp_r];
  end

endmodule : pixel_fifo

/* fb_source_model.sv */
// frame buffer source model: offers pixel words on a valid/ready stream
// assumes the bench picks the word to offer and whether the stream runs
`timescale 1ns/1ps
module fb_source_model
  import vdac_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire pixel_word_t word,
  input  wire logic        pix_ready_r,
  output pixel_word_t      pix_in,
  output logic             pix_valid
);
  // hold an offered word until taken; idle lines wander so stale data never matches
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pix_valid <= 1'b0;
      pix_in    <= '0;
    end else if (pix_valid && !pix_ready_r) begin
      pix_valid <= 1'b1;
    end else if (run) begin
      pix_valid <= 1'b1;
      pix_in    <= word;
    end else begin
      pix_valid <= 1'b0;
      pix_in    <= ~pix_in;
    end
  end
endmodule : fb_source_model

/* pixel_mux_clock_and_video_level_ctrl_bench.sv */
// self-checking bench for the pixel clock and video level block
// assumes the package and the frame buffer source model are compiled first
`timescale 1ns/1ps
module pixel_mux_clock_and_video_level_ctrl_bench;
  import vdac_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
  logic        clock = 0, reset_n = 0, host_addr_sel = 0, host_wr = 0, host_rd = 0, video_run = 1, src_on = 0;
  logic [9:0]  host_wdata = '0, host_rdata_r, q;
  pixel_word_t pix_in, w, src_word = '0;
  logic        pix_valid, pix_ready_r, green_sync_on_r, phase_sync_output_r;
  logic        word_load_clock_out_r, programmable_clock_out_r;
  chan_out_t   red_current_out_r, green_current_out_r, blue_current_out_r;
  logic [2:0]  pedestal_on_r;
  logic [7:0]  v, c2;
  int          fails = 0, n_tests = 0, cnt, lat_s, lat_b;
  logic [7:0]  tap_tbl [5] = '{8'h00, 8'h04, 8'h14, 8'h4c, 8'hfc};

  // free-running pixel clock, 100 ns period
  always #50 clock = ~clock;

  pixel_clock_video_ctrl uut (.clock, .reset_n, .host_addr_sel, .host_wr, .host_rd, .host_wdata, .host_rdata_r,
    .pix_in, .pix_valid, .pix_ready_r, .video_run, .red_current_out_r, .green_current_out_r, .blue_current_out_r,
    .pedestal_on_r, .green_sync_on_r, .phase_sync_output_r, .word_load_clock_out_r, .programmable_clock_out_r);
  fb_source_model src (.clock, .reset_n, .run(src_on), .word(src_word), .pix_ready_r, .pix_in, .pix_valid);

  function automatic int mfac(input logic [1:0] m);
    return (m == MUX_4TO1) ? 4 : (m == MUX_2TO1) ? 2 : 1;
  endfunction : mfac

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // one write strobe; an idle cycle follows so strobes never merge
  task automatic hwr(input logic sel, input logic [7:0] d);
    @(posedge clock);
    host_addr_sel <= sel;
    host_wr       <= 1'b1;
    host_wdata    <= {2'h0, d};
    @(posedge clock);
    host_wr <= 1'b0;
  endtask : hwr

  task automatic hrd(input logic sel, output logic [9:0] d);
    @(posedge clock);
    host_addr_sel <= sel;
    host_rd       <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    #1 d = host_rdata_r;
  endtask : hrd

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    hwr(1'b1, a);
    hwr(1'b0, d);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [9:0] d);
    hwr(1'b1, a);
    hrd(1'b0, d);
  endtask : reg_rd

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // counts high cycles, or rising edges when edg is set
  task automatic count_sig(ref logic s, input int n, input logic edg, output int c);
    logic p;
    c = 0;
    // start after the launching edge has settled so no edge counts twice
    #1 p = s;
    repeat (n) begin
      @(posedge clock) #1;
      if (s && !(edg && p)) c++;
      p = s;
    end
  endtask : count_sig

  // cycles from sync and blank falling together until the phase pulse
  task automatic phase_lat(input logic [7:0] cmd3, input logic trig, output int lat);
    reg_wr(ADDR_CR2, {6'h0, trig, 1'b0});
    reg_wr(ADDR_CMD3, cmd3);
    src_word <= {2'b11, 30'h0};
    tick(80);
    src_word <= '0;
    for (lat = 0; lat < 300 && phase_sync_output_r !== 1'b1; lat++) @(posedge clock) #1;
    if (lat == 300) begin
      fails++;
      close_out();
    end
  endtask : phase_lat

  initial begin
    void'($urandom(28));
    tick(2);
    #1 `CHK("rdata_rst", 10'h000, host_rdata_r)
    `CHK("bits_n_rst", 10'h3ff, blue_current_out_r.bits_n)
    @(posedge clock) reset_n <= 1'b1;
    tick(2);
    hrd(1'b1, q); `CHK("addr_rst", 10'h000, q)
    reg_rd(ADDR_CMD3, q); `CHK("cmd3_rst", 10'h000, q)
    repeat (6) begin
      v = 8'($urandom);
      if (v[7:6] == MUX_RSVD) v[7:6] = MUX_4TO1;
      reg_wr(ADDR_CMD3, v);
      reg_rd(ADDR_CMD3, q); `CHK("cmd3", {2'h0, v}, q)
    end
    reg_wr(ADDR_CMD3, 8'hc0);
    reg_wr(ADDR_CMD3, 8'h81);
    reg_rd(ADDR_CMD3, q); `CHK("cmd3_rsvd", 10'h0c1, q)
    reg_wr(ADDR_REV, v);
    reg_rd(ADDR_REV, q); `CHK("rev", {2'h0, REVISION_CODE}, q)
    reg_rd(8'h3a, q); `CHK("unmapped", 10'h000, q)
    hrd(1'b1, q); `CHK("addr", 10'h03a, q)
    $display("test registers done");
    // load strobe per multiplex code, prog clock per divider code
    for (int m = 0; m < 4; m++) if (m != 2) begin
      reg_wr(ADDR_CMD3, {m[1:0], 6'h0});
      tick(8);
      count_sig(word_load_clock_out_r, 16, 1'b0, cnt); `CHK("load", 16 / mfac(m[1:0]), cnt)
    end
    for (int c = 0; c < 4; c++) begin
      reg_wr(ADDR_CMD3, {6'h0, c[1:0]});
      tick(40);
      count_sig(programmable_clock_out_r, 64, 1'b1, cnt); `CHK("prog", 64 / (4 << c), cnt)
    end
    $display("test clocks done");
    // blank deskew shows as extra phase delay when blank triggers
    @(posedge clock) src_on <= 1'b1;
    foreach (tap_tbl[i]) begin
      phase_lat(tap_tbl[i], 1'b0, lat_s);
      phase_lat(tap_tbl[i], 1'b1, lat_b);
      `CHK("blank_tap", int'(tap_tbl[i][5:2]) * mfac(tap_tbl[i][7:6]), lat_b - lat_s)
    end
    $display("test blank delay done");
    reg_wr(ADDR_CMD3, 8'h00);
    for (int i = 0; i < 10; i++) begin
      w = pixel_word_t'($urandom);
      if (i == 0) w = {2'b11, 30'h3fff_ffff};
      if (i == 1) w = {2'b11, 30'h0};
      c2 = 8'($urandom) & 8'h0c;
      reg_wr(ADDR_CR2, c2);
      src_word <= w;
      tick(12);
      #1 `CHK("red", w.blank_n ? w.red : 10'h0, red_current_out_r.bits)
      `CHK("red_n", w.blank_n ? ~w.red : 10'h3ff, red_current_out_r.bits_n)
      `CHK("green", w.blank_n ? w.green : 10'h0, green_current_out_r.bits)
      `CHK("green_n", w.blank_n ? ~w.green : 10'h3ff, green_current_out_r.bits_n)
      `CHK("blue", w.blank_n ? w.blue : 10'h0, blue_current_out_r.bits)
      `CHK("blue_n", w.blank_n ? ~w.blue : 10'h3ff, blue_current_out_r.bits_n)
      `CHK("pedestal", w.blank_n ? {3{c2[CR2_PED_BIT]}} : 3'h0, pedestal_on_r)
      `CHK("gsync", c2[CR2_SYNC_BIT] & w.sync_n, green_sync_on_r)
    end
    $display("test levels done");
    // stall the drain and fill the buffer until it refuses
    @(posedge clock) src_on <= 1'b0;
    tick(20);
    video_run <= 1'b0;
    src_on    <= 1'b1;
    cnt = 0;
    repeat (50) begin
      @(negedge clock);
      if (pix_valid && pix_ready_r) cnt++;
    end
    // the empty drain register takes one word even while stalled, so one more than the depth
    `CHK("fill", FIFO_DEPTH + 1, cnt)
    `CHK("full", 1'b0, pix_ready_r)
    @(posedge clock) src_on <= 1'b0;
    video_run <= 1'b1;
    tick(50);
    #1 `CHK("drained", 1'b1, pix_ready_r)
    $display("test buffer done");
    close_out();
  end
endmodule : pixel_mux_clock_and_video_level_ctrl_bench
